// >>> rtl/freq_offset_defines.svh
`ifndef FREQ_OFFSET_DEFINES_SVH
`define FREQ_OFFSET_DEFINES_SVH
// byte addresses of the register map
`define CTRL_ADDR 8'h1b
`define SHIFT_ADDR 8'h1c
`define DATA_BASE 8'h1d
`define DATA_LOW_IDX 8'h03
`define FACT_BASE 8'h21
`define FACT_LAST_IDX 8'h0b
`define CFG_BASE 8'h2d
`define CFG_LAST_IDX 8'h05
// control register fields
`define CLR_BIT 7
`define ENA_BIT 6
`define REL_BIT 5
`define STREAM_BIT 4
`define SIZE_MSB 1
`define SIZE_LSB 0
// reset values
`define CTRL_RESET 8'h00
`define SHIFT_RESET 8'h00
`define OFFSET_RESET 32'h0000_0000
`define HOLD_RESET 24'h00_0000
`define COUNT_RESET 2'h0
`define BYTE_ZERO 8'h00
// sign saturation limits
`define SAT_MAX 32'h7fff_ffff
`define SAT_MIN 32'h8000_0000
`endif

// >>> rtl/freq_offset_pkg.sv
package freq_offset_pkg;
  typedef logic [31:0] offset_type;
  typedef logic [56:0] wide_type;
  typedef logic [7:0] byte_type;
endpackage : freq_offset_pkg

// >>> rtl/freq_offset_update_regs.sv
// Function
// - clear bit zeroes offset, holds, stream sync
// - clear works even while disabled
// - clear leaves shift amount untouched
// - any control write resets stream sync
// - signed 32-bit data register at 0x1d
// - value is signed 11.21 ppm offset
// - big-endian, low byte at base plus three
// - upper bytes held, low byte applies
// - direct mode: any byte, any order
// - reads return live internal offset
// - readback independent of write mode
// - read-only factory identification arrays
// - sign-extend 57, shift, saturate 32
// - relative adds, absolute replaces offset
// - streaming accepts only low byte address
// - disabled ignores all control but clear
`timescale 1ns/1ns
`include "freq_offset_defines.svh"
module freq_offset_update_regs
  import freq_offset_pkg::*;
#(
  // arbitrary identification values
  parameter logic [95:0] device_ident_value = 96'h0123_4567_89ab_cdef_0011_2233,
  parameter logic [47:0] config_ident_value = 48'h0a0b_0c0d_0e0f
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic [31:0] offset_value_out,
  output logic sat_pos_out,
  output logic sat_neg_out
);

  byte_type ctrl_q;
  byte_type shift_q;
  offset_type offset_q;
  logic [23:0] hold_q;
  logic [1:0] stream_cnt_q;
  byte_type rdata_q;
  logic sat_pos_q;
  logic sat_neg_q;

  // sign saturation of a 57-bit value to 32 bits
  function automatic offset_type sat32(input wide_type v);
    if (&v[56:31] || ~|v[56:31]) begin
      sat32 = v[31:0];
    end else begin
      sat32 = v[56] ? `SAT_MIN : `SAT_MAX;
    end
  endfunction : sat32

  // bottom bytes selected by size code, sign-extended to 57 bits
  function automatic wide_type extend(input offset_type raw,
                                      input logic [1:0] sz);
    unique case (sz)
      2'h0: extend = {{49{raw[7]}}, raw[7:0]};
      2'h1: extend = {{41{raw[15]}}, raw[15:0]};
      2'h2: extend = {{33{raw[23]}}, raw[23:0]};
      2'h3: extend = {{25{raw[31]}}, raw};
    endcase
  endfunction : extend

  // address decode
  byte_type data_idx;
  byte_type fact_idx;
  byte_type cfg_idx;
  logic in_data;
  logic in_fact;
  logic in_cfg;
  logic ctrl_wr;
  logic clr_wr;
  logic ena;
  logic stream;
  logic rel;
  logic [1:0] size;
  assign data_idx = reg_addr_in - `DATA_BASE;
  assign fact_idx = reg_addr_in - `FACT_BASE;
  assign cfg_idx = reg_addr_in - `CFG_BASE;
  assign in_data = reg_addr_in >= `DATA_BASE &&
                   data_idx <= `DATA_LOW_IDX;
  assign in_fact = reg_addr_in >= `FACT_BASE &&
                   fact_idx <= `FACT_LAST_IDX;
  assign in_cfg = reg_addr_in >= `CFG_BASE && cfg_idx <= `CFG_LAST_IDX;
  assign ctrl_wr = reg_write_in && reg_addr_in == `CTRL_ADDR;
  assign clr_wr = ctrl_wr && reg_wdata_in[`CLR_BIT];
  // mode bits only count while enabled
  assign ena = ctrl_q[`ENA_BIT];
  assign stream = ena && ctrl_q[`STREAM_BIT];
  assign rel = ena && ctrl_q[`REL_BIT];
  assign size = ena ? ctrl_q[`SIZE_MSB:`SIZE_LSB] : 2'h3;

  logic low_wr;
  logic upper_wr;
  logic stream_last;
  logic apply;
  assign low_wr = reg_write_in && in_data && data_idx == `DATA_LOW_IDX;
  assign upper_wr = reg_write_in && in_data &&
                    data_idx != `DATA_LOW_IDX && !stream;
  assign stream_last = stream_cnt_q == size;
  assign apply = low_wr && ena && (!stream || stream_last);

  // update arithmetic
  offset_type raw_value;
  wide_type shifted;
  wide_type sum;
  wide_type result;
  offset_type next_offset;
  assign raw_value = {hold_q, reg_wdata_in};
  assign shifted = extend(raw_value, size) << shift_q[5:0];
  assign sum = shifted + {{25{offset_q[31]}}, offset_q};
  assign result = rel ? sum : shifted;
  assign next_offset = sat32(result);

  // control register; clear bit self-clears
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ctrl_q <= `CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_q <= reg_wdata_in & ~(8'h01 << `CLR_BIT);
    end
  end

  // shift amount, untouched by the clear
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      shift_q <= `SHIFT_RESET;
    end else if (reg_write_in && reg_addr_in == `SHIFT_ADDR) begin
      shift_q <= reg_wdata_in;
    end
  end

  // holding bytes: addressed in direct mode, shifted in when streaming
  always_ff @(posedge clk_in) begin
    if (reset_in || clr_wr) begin
      hold_q <= `HOLD_RESET;
    end else if (upper_wr) begin
      unique case (data_idx[1:0])
        2'h0: hold_q[23:16] <= reg_wdata_in;
        2'h1: hold_q[15:8] <= reg_wdata_in;
        2'h2: hold_q[7:0] <= reg_wdata_in;
        2'h3: hold_q <= hold_q;
      endcase
    end else if (low_wr && stream && !stream_last) begin
      hold_q <= {hold_q[15:0], reg_wdata_in};
    end
  end

  // streaming byte position
  always_ff @(posedge clk_in) begin
    if (reset_in || ctrl_wr) begin
      stream_cnt_q <= `COUNT_RESET;
    end else if (low_wr && stream) begin
      stream_cnt_q <= stream_last ? `COUNT_RESET : stream_cnt_q + 2'h1;
    end
  end

  // internal offset and saturation flags
  always_ff @(posedge clk_in) begin
    if (reset_in || clr_wr) begin
      offset_q <= `OFFSET_RESET;
      sat_pos_q <= 1'b0;
      sat_neg_q <= 1'b0;
    end else if (apply) begin
      offset_q <= next_offset;
      sat_pos_q <= !result[56] && next_offset != result[31:0];
      sat_neg_q <= result[56] && next_offset != result[31:0];
    end
  end

  // read data: live offset, never the holds; ids read-only
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rdata_q <= `BYTE_ZERO;
    end else if (reg_read_in) begin
      if (in_data) begin
        rdata_q <= offset_q[(5'd24 - {data_idx[1:0], 3'h0}) +: 8];
      end else if (in_fact) begin
        rdata_q <= device_ident_value[(7'd88 - 7'(fact_idx) * 7'd8) +: 8];
      end else if (in_cfg) begin
        rdata_q <= config_ident_value[(6'd40 - 6'(cfg_idx) * 6'd8) +: 8];
      end else if (reg_addr_in == `CTRL_ADDR) begin
        rdata_q <= ctrl_q;
      end else if (reg_addr_in == `SHIFT_ADDR) begin
        rdata_q <= shift_q;
      end else begin
        rdata_q <= `BYTE_ZERO;
      end
    end
  end

  assign reg_rdata_out = rdata_q;
  assign offset_value_out = offset_q;
  assign sat_pos_out = sat_pos_q;
  assign sat_neg_out = sat_neg_q;

  // checks
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);

  chk_clear_zeroes: assert property (
      clr_wr |=> offset_q == `OFFSET_RESET && hold_q == `HOLD_RESET)
    else $error("clear did not zero offset and holds");
  chk_clear_keeps_shift: assert property (clr_wr |=> $stable(shift_q))
    else $error("clear changed shift amount");
  chk_sync_reset: assert property (ctrl_wr |=> stream_cnt_q == 2'h0)
    else $error("control write left stream sync running");
  chk_apply_on_low: assert property (
      !low_wr && !clr_wr |=> $stable(offset_q))
    else $error("offset changed without a low byte write");
  chk_stream_ignore: assert property (
      stream && reg_write_in && in_data && data_idx != `DATA_LOW_IDX
      |=> $stable(hold_q))
    else $error("upper byte accepted while streaming");
  chk_disabled_idle: assert property (
      !ena && low_wr && !clr_wr |=> $stable(offset_q))
    else $error("offset applied while disabled");
  chk_read_live: assert property (
      reg_read_in && in_data && data_idx == `DATA_LOW_IDX
      |=> reg_rdata_out == $past(offset_q[7:0]))
    else $error("low byte read is not the live offset");
  chk_abs_direct: assert property (
      apply && !rel && !stream && size == 2'h3 && shift_q == `SHIFT_RESET
      |=> offset_q == $past(raw_value))
    else $error("absolute direct write not applied as written");
  chk_ident_ro: assert property (
      reg_read_in && reg_addr_in == `FACT_BASE
      |=> reg_rdata_out == device_ident_value[95:88])
    else $error("identification byte wrong");
  cov_stream_apply: cover property (apply && stream);
  cov_rel_sat: cover property (apply && rel ##1 (sat_pos_q || sat_neg_q));
  cov_clear_disabled: cover property (clr_wr && !ena);

endmodule : freq_offset_update_regs

// >>> testbench/offset_host_model.sv
`timescale 1ns/1ns
module offset_host_model (
  input wire logic clk_in,
  output logic write_out,
  output logic read_out,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out,
  input wire logic [7:0] rdata_in
);
  // idle bus with no strobe at time zero
  initial {write_out, read_out, addr_out, wdata_out} = 18'h00000;
  // byte write; released lines show the inverse of the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    #1 write_out = 1'b1;
    addr_out = a;
    wdata_out = d;
    @(posedge clk_in);
    #1 write_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
  endtask : wr
  // byte read; data is registered at the taken edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    #1 read_out = 1'b1;
    addr_out = a;
    @(posedge clk_in);
    #1 read_out = 1'b0;
    addr_out = ~a;
    d = rdata_in;
  endtask : rd
  // all four data bytes, high byte first
  task automatic rd32(output logic [31:0] v);
    logic [7:0] b;
    for (int i = 0; i < 4; i++) begin
      rd(8'h1d + 8'(i), b);
      v = {v[23:0], b};
    end
  endtask : rd32
endmodule : offset_host_model

// >>> testbench/freq_offset_update_regs_tb_top.sv
`timescale 1ns/1ns
module freq_offset_update_regs_tb_top;
  import freq_offset_pkg::*;
  logic clk_in = 1'b0;
  logic reset_in, wr_s, rd_s, sp, sn;
  logic [7:0] addr, wdata, rdata, b;
  offset_type off, v;
  int errors, checked, cycles;
  // arbitrary identification values handed to the design
  localparam logic [95:0] dev_ident = 96'hfedc_ba98_7654_3210_a5a5_5a5a;
  localparam logic [47:0] cfg_ident = 48'h1357_9bdf_2468;
  // 250 MHz clock
  initial forever #2 clk_in = ~clk_in;
  freq_offset_update_regs #(.device_ident_value(dev_ident),
    .config_ident_value(cfg_ident)) dut (.clk_in(clk_in), .reset_in(reset_in),
    .reg_write_in(wr_s), .reg_read_in(rd_s), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_rdata_out(rdata), .offset_value_out(off),
    .sat_pos_out(sp), .sat_neg_out(sn));
  offset_host_model h (.clk_in(clk_in), .write_out(wr_s), .read_out(rd_s),
    .addr_out(addr), .wdata_out(wdata), .rdata_in(rdata));
  // compare and count
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) errors++;
    if (s !== e) $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
  endtask : check
  // counts, verdict, end of run
  task automatic give_verdict;
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict
  // hang guard
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) errors++;
    if (cycles == 5000) give_verdict();
  end
  // reset value, out-of-order direct writes, identification read
  task automatic t_direct;
    check(off, 32'h0);
    h.wr(8'h1b, 8'hc3);
    h.wr(8'h1f, 8'h56);
    h.wr(8'h1d, 8'h12);
    h.wr(8'h1e, 8'h34);
    check(off, 32'h0);
    h.wr(8'h20, 8'h78);
    h.rd32(v);
    check(v, 32'h1234_5678);
    h.wr(8'h21, 8'h00);
    h.rd(8'h21, b);
    check({24'h0, b}, {24'h0, dev_ident[95:88]});
    h.rd(8'h2c, b);
    check({24'h0, b}, {24'h0, dev_ident[7:0]});
    h.rd(8'h2d, b);
    check({24'h0, b}, {24'h0, cfg_ident[47:40]});
    $display("t_direct done");
  endtask : t_direct
  // stream restart, clear while disabled, stream ignores upper bytes
  task automatic t_stream;
    h.wr(8'h1b, 8'hd1);
    h.wr(8'h20, 8'haa);
    h.wr(8'h1b, 8'h51);
    h.wr(8'h20, 8'h12);
    h.wr(8'h20, 8'h34);
    h.rd32(v);
    check(v, 32'h1234);
    h.wr(8'h1c, 8'h04);
    h.wr(8'h1b, 8'h00);
    h.wr(8'h20, 8'h77);
    check(off, 32'h1234);
    h.wr(8'h1b, 8'h80);
    check(off, 32'h0);
    h.rd(8'h1c, b);
    check({24'h0, b}, 32'h4);
    h.wr(8'h1b, 8'h50);
    h.wr(8'h1d, 8'h55);
    h.wr(8'h1b, 8'h43);
    h.wr(8'h20, 8'h05);
    check(off, 32'h50);
    $display("t_stream done");
  endtask : t_stream
  // relative add with shift, then saturation; flags folded into top bits
  task automatic t_math;
    h.wr(8'h1b, 8'h61);
    h.wr(8'h1f, 8'hff);
    h.wr(8'h20, 8'hf0);
    check(off, 32'hffff_ff50);
    h.wr(8'h1c, 8'h1f);
    h.wr(8'h1b, 8'h40);
    h.wr(8'h20, 8'h01);
    check(off ^ {sp, sn, 30'h0}, 32'hffff_ffff);
    h.wr(8'h20, 8'hfe);
    check(off ^ {sp, sn, 30'h0}, 32'hc000_0000);
    $display("t_math done");
  endtask : t_math
  // reset for 16 cycles, then the scenarios
  initial begin
    reset_in = 1'b1;
    repeat (16) @(posedge clk_in);
    #1 reset_in = 1'b0;
    t_direct();
    t_stream();
    t_math();
    give_verdict();
  end
endmodule : freq_offset_update_regs_tb_top
